// [rtl/dual_register_file_datapath.sv]
// Two general-purpose register files with unit ports, cross paths, fetch and data ports
// Overview of operation
// (RL1) Two files, sixteen 32-bit registers each
// (RL2) Any register serves data, address, condition
// (RL3) Long: low even register, high odd
// (RL4) One register holds two 16-bit halves
// (RL5) Long pairs aligned even; even number given
// (RL6) Long read ignores odd upper 24 bits
// (RL7) Long write zero-fills odd upper 24 bits
// (RL8) Each side writes only its own file
// (RL9) Eight dedicated write ports, all concurrent
// (RL10) Two 32-bit read ports per unit
// (RL11) Logic and shift units get 8-bit ports
// (RL12) Eight 32-bit instructions delivered per cycle
// (RL13) Single 256-bit program fetch port
// (RL14) Two 32-bit data ports, byte addresses
// (RL15) Only second-side shift unit moves control
// (RL16) Offsets: 5-bit both, 15-bit second only
// (RL17) Logic units: 32/40-bit arithmetic, counts
// (RL18) Shift units: shifts, fields, branches, constants
// (RL19) Multiply units: 16 by 16 products
// (RL20) Address units: linear and circular add/subtract
// (RL21) One cross-path reader per side per packet
// (RL22) Cross-selectable inputs per unit type
// (RL23) Same-cycle reads see old contents
`timescale 1ns/1ps
`default_nettype none
`include "dual_register_file_defs.svh"
module dual_register_file_datapath
  import dual_register_file_pkg::*;
(
  input  wire logic                                  clk,
  input  wire logic                                  nrst,
  input  wire unit_req_t [`NUM_UNITS-1:0]            unit_req,
  output var  unit_rsp_t [`NUM_UNITS-1:0]            unit_rsp,
  output var  logic      [`NUM_SIDES-1:0]            cross_conflict,
  input  wire logic      [`NUM_SIDES-1:0][`REG_AW-1:0] cond_addr,
  output var  logic      [`NUM_SIDES-1:0]            cond_true,
  input  wire logic      [`NUM_SIDES-1:0][`WORD_W-1:0] circ_mask,
  output var  mem_req_t  [`NUM_SIDES-1:0]            mem_req,
  input  wire logic      [`WORD_W-1:0]               ctrl_rdata,
  output var  logic                                  ctrl_we,
  output var  logic      [`WORD_W-1:0]               ctrl_wdata,
  input  wire logic                                  fetch_valid,
  input  wire logic      [`FETCH_W-1:0]              fetch_packet,
  output var  logic                                  inst_valid,
  output var  logic      [`NUM_UNITS-1:0][`WORD_W-1:0] inst
);

  logic [`NUM_SIDES-1:0][`NUM_REGS-1:0][`WORD_W-1:0] rf_reg;
  logic [`NUM_SIDES-1:0][`NUM_REGS-1:0][`WORD_W-1:0] rf_next;
  logic [`NUM_SIDES-1:0][`NUM_REGS-1:0]              zfill;
  unit_rsp_t [`NUM_UNITS-1:0]                        rsp_reg;
  unit_rsp_t [`NUM_UNITS-1:0]                        rsp_next;
  logic [`NUM_UNITS-1:0]                             xgnt;
  logic [`NUM_SIDES-1:0]                             xconf_reg;
  logic [`NUM_SIDES-1:0]                             xconf_next;
  logic [`NUM_SIDES-1:0]                             cond_reg;
  logic [`NUM_SIDES-1:0]                             cond_next;
  mem_req_t [`NUM_SIDES-1:0]                         mem_reg;
  mem_req_t [`NUM_SIDES-1:0]                         mem_next;
  logic                                              ctrl_we_reg;
  logic                                              ctrl_we_next;
  logic [`WORD_W-1:0]                                ctrl_wdata_reg;
  logic [`WORD_W-1:0]                                ctrl_wdata_next;
  logic                                              inst_valid_reg;
  logic                                              inst_valid_next;
  logic [`FETCH_W-1:0]                               inst_reg;
  logic [`FETCH_W-1:0]                               inst_next;

  // Register file writes; later units in the loop win on a clash
  always_comb
  begin
    rf_next = rf_reg;
    zfill   = '0;
    for (int s = 0; s < `NUM_SIDES; s++)
    begin
      for (int u = 0; u < `UNITS_PER_SIDE; u++)
      begin
        // Writes land only in the unit's own side [RL8] [RL9]
        if (s * `UNITS_PER_SIDE + u == `CTRL_UNIT_IDX && unit_req[s * `UNITS_PER_SIDE + u].ctrl_rd)
        begin
          rf_next[s][unit_req[`CTRL_UNIT_IDX].wr_addr] = ctrl_rdata; // [RL15]
          zfill[s][unit_req[`CTRL_UNIT_IDX].wr_addr]   = 1'b0;
        end
        else if (u <= `UNIT_SHIFT && unit_req[s * `UNITS_PER_SIDE + u].long_wr_en)
        begin
          // Pair aligned on the even number, high byte to odd [RL3] [RL5] [RL11] [RL17] [RL18]
          rf_next[s][{unit_req[s * `UNITS_PER_SIDE + u].wr_addr[3:1], 1'b0}] =
            unit_req[s * `UNITS_PER_SIDE + u].wr_data;
          rf_next[s][{unit_req[s * `UNITS_PER_SIDE + u].wr_addr[3:1], 1'b1}] =
            {{`ZFILL_W{1'b0}}, unit_req[s * `UNITS_PER_SIDE + u].wr_hi}; // [RL7]
          zfill[s][{unit_req[s * `UNITS_PER_SIDE + u].wr_addr[3:1], 1'b1}] = 1'b1;
        end
        else if (unit_req[s * `UNITS_PER_SIDE + u].wr_en)
        begin
          // Full 32-bit word, products of multiply units included [RL19]
          rf_next[s][unit_req[s * `UNITS_PER_SIDE + u].wr_addr] = unit_req[s * `UNITS_PER_SIDE + u].wr_data;
          zfill[s][unit_req[s * `UNITS_PER_SIDE + u].wr_addr]   = 1'b0;
        end
      end
    end
  end

  // Cross grants, operand reads, condition tests
  always_comb
  begin
    logic       taken;
    logic       want;
    logic [3:0] a2;
    logic       o2;
    logic       o1;
    taken      = 1'b0;
    want       = 1'b0;
    a2         = '0;
    o2         = 1'b0;
    o1         = 1'b0;
    xgnt       = '0;
    xconf_next = '0;
    rsp_next   = '0;
    for (int s = 0; s < `NUM_SIDES; s++)
    begin
      taken = 1'b0;
      for (int u = 0; u < `UNITS_PER_SIDE; u++)
      begin
        // Logic units select both inputs, shift and multiply only the second [RL22]
        want = (u != `UNIT_ADDR && unit_req[s * `UNITS_PER_SIDE + u].cross2) ||
               (u == `UNIT_LOGIC && unit_req[s * `UNITS_PER_SIDE + u].cross1);
        // First requester keeps the cross path, the rest read locally [RL21]
        xgnt[s * `UNITS_PER_SIDE + u] = want && !taken;
        if (want && taken)
        begin
          xconf_next[s] = 1'b1;
        end
        taken = taken | want;
        o1 = xgnt[s * `UNITS_PER_SIDE + u] && u == `UNIT_LOGIC && unit_req[s * `UNITS_PER_SIDE + u].cross1;
        o2 = xgnt[s * `UNITS_PER_SIDE + u] && unit_req[s * `UNITS_PER_SIDE + u].cross2;
        a2 = unit_req[s * `UNITS_PER_SIDE + u].rd2_addr;
        if (u <= `UNIT_SHIFT && unit_req[s * `UNITS_PER_SIDE + u].long_rd)
        begin
          a2 = {a2[3:1], 1'b0}; // [RL5]
        end
        // Old contents are sampled, so writes show only next cycle [RL10] [RL23] [RL2] [RL4]
        rsp_next[s * `UNITS_PER_SIDE + u].first_source_operand =
          rf_reg[o1 ? 1 - s : s][unit_req[s * `UNITS_PER_SIDE + u].rd1_addr];
        rsp_next[s * `UNITS_PER_SIDE + u].second_source_operand = rf_reg[o2 ? 1 - s : s][a2];
        if (u <= `UNIT_SHIFT && unit_req[s * `UNITS_PER_SIDE + u].long_rd)
        begin
          // Only the low byte of the odd register counts [RL6] [RL11]
          rsp_next[s * `UNITS_PER_SIDE + u].second_source_hi = rf_reg[o2 ? 1 - s : s][{a2[3:1], 1'b1}][`HI_W-1:0];
        end
      end
      cond_next[s] = rf_reg[s][cond_addr[s]] != '0; // [RL2]
    end
  end

  // Address units, data ports, control moves and fetch
  always_comb
  begin
    logic [`WORD_W-1:0] base;
    logic [`WORD_W-1:0] off;
    logic [`WORD_W-1:0] sum;
    base = '0;
    off  = '0;
    sum  = '0;
    for (int s = 0; s < `NUM_SIDES; s++)
    begin
      base = rf_reg[s][unit_req[s * `UNITS_PER_SIDE + `UNIT_ADDR].rd1_addr];
      // Long offsets only on the second side [RL16]
      if (s == 1 && unit_req[s * `UNITS_PER_SIDE + `UNIT_ADDR].long_off)
      begin
        off = {{(`WORD_W - `LONG_OFF_W){1'b0}}, unit_req[s * `UNITS_PER_SIDE + `UNIT_ADDR].offset};
      end
      else
      begin
        off = {{(`WORD_W - `SHORT_OFF_W){1'b0}},
               unit_req[s * `UNITS_PER_SIDE + `UNIT_ADDR].offset[`SHORT_OFF_W-1:0]};
      end
      sum = unit_req[s * `UNITS_PER_SIDE + `UNIT_ADDR].mem_sub ? base - off : base + off; // [RL20]
      if (unit_req[s * `UNITS_PER_SIDE + `UNIT_ADDR].mem_circ)
      begin
        sum = (base & ~circ_mask[s]) | (sum & circ_mask[s]); // [RL20]
      end
      // One 32-bit byte-addressed data port per side [RL14]
      mem_next[s].valid = unit_req[s * `UNITS_PER_SIDE + `UNIT_ADDR].mem_en;
      mem_next[s].store = unit_req[s * `UNITS_PER_SIDE + `UNIT_ADDR].mem_store;
      mem_next[s].addr  = sum;
      mem_next[s].wdata = rf_reg[s][unit_req[s * `UNITS_PER_SIDE + `UNIT_ADDR].rd2_addr];
    end
    // Other units have no path to control registers [RL15]
    ctrl_we_next    = unit_req[`CTRL_UNIT_IDX].ctrl_wr;
    ctrl_wdata_next = rf_reg[1][unit_req[`CTRL_UNIT_IDX].rd2_addr];
    // Whole 256-bit packet split into eight instructions [RL12] [RL13]
    inst_valid_next = fetch_valid;
    inst_next       = fetch_valid ? fetch_packet : inst_reg;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rf_reg         <= '0; // [RL1]
      rsp_reg        <= '0;
      xconf_reg      <= '0;
      cond_reg       <= '0;
      mem_reg        <= '0;
      ctrl_we_reg    <= 1'b0;
      ctrl_wdata_reg <= '0;
      inst_valid_reg <= 1'b0;
      inst_reg       <= '0;
    end
    else
    begin
      rf_reg         <= rf_next;
      rsp_reg        <= rsp_next;
      xconf_reg      <= xconf_next;
      cond_reg       <= cond_next;
      mem_reg        <= mem_next;
      ctrl_we_reg    <= ctrl_we_next;
      ctrl_wdata_reg <= ctrl_wdata_next;
      inst_valid_reg <= inst_valid_next;
      inst_reg       <= inst_next;
    end
  end

  assign unit_rsp       = rsp_reg;
  assign cross_conflict = xconf_reg;
  assign cond_true      = cond_reg;
  assign mem_req        = mem_reg;
  assign ctrl_we        = ctrl_we_reg;
  assign ctrl_wdata     = ctrl_wdata_reg;
  assign inst_valid     = inst_valid_reg;
  assign inst           = inst_reg;

  // Checker helpers
  logic [`WORD_W-1:0] exp_rd1;
  logic [`WORD_W-1:0] exp_base_a;
  logic               a_wr;
  logic [`HI_W-1:0]   exp_hi0;
  logic [`WORD_W-1:0] exp_ctrl;
  logic [`WORD_W-1:0] exp_rd2_a;
  logic [`REG_AW-1:0] even_a;
  assign exp_rd1    = rf_reg[0][unit_req[`UNIT_MULT].rd1_addr];
  assign exp_base_a = rf_reg[0][unit_req[`UNIT_ADDR].rd1_addr];
  assign a_wr       = |{unit_req[0].wr_en, unit_req[0].long_wr_en, unit_req[1].wr_en, unit_req[1].long_wr_en,
                        unit_req[2].wr_en, unit_req[3].wr_en};
  assign exp_hi0    = rf_reg[0][{unit_req[0].rd2_addr[3:1], 1'b1}][`HI_W-1:0];
  assign exp_ctrl   = rf_reg[1][unit_req[`CTRL_UNIT_IDX].rd2_addr];
  assign exp_rd2_a  = rf_reg[0][unit_req[`UNIT_ADDR].rd2_addr];
  assign even_a     = {unit_req[1].wr_addr[3:1], 1'b0};

  chk_zero_fill: assert property (@(posedge clk) disable iff (!nrst) // [RL7]
    zfill[0][3] |=> rf_reg[0][3][`WORD_W-1:`HI_W] == '0)
    else $error("odd register of long result not zero-filled");
  chk_read_old: assert property (@(posedge clk) disable iff (!nrst) // [RL23]
    1'b1 |=> unit_rsp[`UNIT_MULT].first_source_operand == $past(exp_rd1))
    else $error("read port did not return the previous contents");
  chk_cross_single: assert property (@(posedge clk) disable iff (!nrst) // [RL21]
    $onehot0(xgnt[3:0]) && $onehot0(xgnt[7:4]))
    else $error("more than one cross path grant on a side");
  chk_hi_masked: assert property (@(posedge clk) disable iff (!nrst) // [RL11]
    unit_rsp[`UNIT_MULT].second_source_hi == '0 && unit_rsp[`UNIT_ADDR].second_source_hi == '0)
    else $error("high byte driven on a unit without long port");
  chk_ctrl_only_b: assert property (@(posedge clk) disable iff (!nrst) // [RL15]
    ctrl_we |-> $past(unit_req[`CTRL_UNIT_IDX].ctrl_wr))
    else $error("control write without second-side shift unit request");
  chk_fetch_split: assert property (@(posedge clk) disable iff (!nrst) // [RL12]
    fetch_valid |=> inst_valid && inst[7] == $past(fetch_packet[`FETCH_W-1:`FETCH_W-`WORD_W]))
    else $error("fetch packet not split into instructions");
  chk_short_offset: assert property (@(posedge clk) disable iff (!nrst) // [RL16]
    unit_req[`UNIT_ADDR].mem_en && !unit_req[`UNIT_ADDR].mem_sub && !unit_req[`UNIT_ADDR].mem_circ
    |=> mem_req[0].addr - $past(exp_base_a) <= 32'h0000_001f)
    else $error("first side offset exceeds five bits");
  chk_side_write: assert property (@(posedge clk) disable iff (!nrst) // [RL8]
    !a_wr |=> rf_reg[0] == $past(rf_reg[0]))
    else $error("first file changed without a first-side write");
  chk_cond_test: assert property (@(posedge clk) disable iff (!nrst) // [RL2]
    1'b1 |=> cond_true[1] == ($past(rf_reg[1][cond_addr[1]]) != '0))
    else $error("condition test mismatch");
  chk_long_hi: assert property (@(posedge clk) disable iff (!nrst) // [RL6]
    unit_req[0].long_rd && !unit_req[0].cross2
    |=> unit_rsp[0].second_source_hi == $past(exp_hi0))
    else $error("long read high byte not taken from odd register");
  chk_pair_even: assert property (@(posedge clk) disable iff (!nrst) // [RL3] [RL5]
    unit_req[1].long_wr_en && !unit_req[2].wr_en && !unit_req[3].wr_en
    |=> rf_reg[0][$past(even_a)] == $past(unit_req[1].wr_data)
        && rf_reg[0][$past(even_a) | 4'h1] == {{`ZFILL_W{1'b0}}, $past(unit_req[1].wr_hi)})
    else $error("long result not stored in aligned register pair");
  chk_mem_valid: assert property (@(posedge clk) disable iff (!nrst) // [RL14]
    1'b1 |=> mem_req[1].valid == $past(unit_req[7].mem_en))
    else $error("second side data port valid mismatch");
  chk_ctrl_data: assert property (@(posedge clk) disable iff (!nrst) // [RL15]
    unit_req[`CTRL_UNIT_IDX].ctrl_wr |=> ctrl_we && ctrl_wdata == $past(exp_ctrl))
    else $error("control write data not taken from second file");
  chk_addr_local: assert property (@(posedge clk) disable iff (!nrst) // [RL22]
    1'b1 |=> unit_rsp[`UNIT_ADDR].second_source_operand == $past(exp_rd2_a))
    else $error("address unit read through the cross path");

  cov_long_write: cover property (@(posedge clk) disable iff (!nrst) unit_req[0].long_wr_en ##1 unit_req[0].long_rd);
  cov_cross_clash: cover property (@(posedge clk) disable iff (!nrst) xconf_next[1]);
  cov_mem_circ: cover property (@(posedge clk) disable iff (!nrst) unit_req[7].mem_en && unit_req[7].mem_circ);
  cov_ctrl_move: cover property (@(posedge clk) disable iff (!nrst) unit_req[5].ctrl_wr ##1 unit_req[5].ctrl_rd);
  cov_fetch_run: cover property (@(posedge clk) disable iff (!nrst) fetch_valid ##1 !fetch_valid);

endmodule : dual_register_file_datapath
`default_nettype wire

// [rtl/dual_register_file_defs.svh]
// Constants of the dual register file datapath
`ifndef DUAL_REGISTER_FILE_DEFS_SVH
`define DUAL_REGISTER_FILE_DEFS_SVH
`define NUM_SIDES     2
`define UNITS_PER_SIDE 4
`define NUM_UNITS     8
`define NUM_REGS      16
`define REG_AW        4
`define WORD_W        32
`define HALF_W        16
`define HI_W          8
`define ZFILL_W       24
`define FETCH_W       256
`define SHORT_OFF_W   5
`define LONG_OFF_W    15
`define UNIT_LOGIC    0
`define UNIT_SHIFT    1
`define UNIT_MULT     2
`define UNIT_ADDR     3
`define CTRL_UNIT_IDX 5
`endif

// [rtl/dual_register_file_pkg.sv]
// Types shared by the dual register file datapath
`include "dual_register_file_defs.svh"
package dual_register_file_pkg;
  typedef struct packed {
    logic [`HALF_W-1:0] upper_half;
    logic [`HALF_W-1:0] lower_half;
  } word_t;
  typedef struct packed {
    logic                   wr_en;
    logic                   long_wr_en;
    logic [`REG_AW-1:0]     wr_addr;
    logic [`WORD_W-1:0]     wr_data;
    logic [`HI_W-1:0]       wr_hi;
    logic [`REG_AW-1:0]     rd1_addr;
    logic [`REG_AW-1:0]     rd2_addr;
    logic                   cross1;
    logic                   cross2;
    logic                   long_rd;
    logic                   ctrl_rd;
    logic                   ctrl_wr;
    logic                   mem_en;
    logic                   mem_store;
    logic                   mem_sub;
    logic                   mem_circ;
    logic                   long_off;
    logic [`LONG_OFF_W-1:0] offset;
  } unit_req_t;
  typedef struct packed {
    word_t              first_source_operand;
    word_t              second_source_operand;
    logic [`HI_W-1:0]   second_source_hi;
  } unit_rsp_t;
  typedef struct packed {
    logic               valid;
    logic               store;
    logic [`WORD_W-1:0] addr;
    logic [`WORD_W-1:0] wdata;
  } mem_req_t;
endpackage : dual_register_file_pkg

// [tb/ctrl_reg_model.sv]
// Control register stand-in on the far side of the register move port
`timescale 1ns/1ps
`default_nettype none
module ctrl_reg_model
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ctrl_we,
  input  wire logic [31:0] ctrl_wdata,
  output var  logic [31:0] ctrl_rdata
);
  logic [31:0] value_reg;
  logic [31:0] value_next;
  always_comb
  begin
    value_next = ctrl_we ? ctrl_wdata : value_reg;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      value_reg <= 32'h0000_0000;
    else
      value_reg <= value_next;
  end
  assign ctrl_rdata = value_reg;
endmodule : ctrl_reg_model
`default_nettype wire

// [tb/dual_register_file_datapath_test.sv]
// Self-checking bench for the dual register file datapath
`timescale 1ns/1ps
`default_nettype none
module dual_register_file_datapath_test;
  import dual_register_file_pkg::*;
  logic             clk = 1'b0;
  logic             nrst = 1'b0;
  unit_req_t [7:0]  req = '0;
  unit_req_t [7:0]  r = '0;
  unit_rsp_t [7:0]  rsp;
  logic [1:0]       cross_conflict;
  logic [1:0][3:0]  cond_addr = '0;
  logic [1:0]       cond_true;
  logic [1:0][31:0] circ_mask = '0;
  mem_req_t [1:0]   mem_req;
  logic [31:0]      ctrl_rdata;
  logic             ctrl_we;
  logic [31:0]      ctrl_wdata;
  logic             fetch_valid = 1'b0;
  logic [255:0]     fetch_packet = '0;
  logic             inst_valid;
  logic [7:0][31:0] inst;
  int               n_fail = 0;
  int               checks = 0;
  always #20 clk = ~clk;
  dual_register_file_datapath dual_register_file_datapath_i (.clk(clk), .nrst(nrst), .unit_req(req),
    .unit_rsp(rsp), .cross_conflict(cross_conflict), .cond_addr(cond_addr), .cond_true(cond_true),
    .circ_mask(circ_mask), .mem_req(mem_req), .ctrl_rdata(ctrl_rdata), .ctrl_we(ctrl_we),
    .ctrl_wdata(ctrl_wdata), .fetch_valid(fetch_valid), .fetch_packet(fetch_packet),
    .inst_valid(inst_valid), .inst(inst));
  ctrl_reg_model ctrl_reg_model_i (.clk(clk), .nrst(nrst), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata),
    .ctrl_rdata(ctrl_rdata));
  function automatic logic [31:0] val(input int k);
    return 32'(32'h0101_0101 * (k + 1));
  endfunction : val
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  // Apply the staged requests for one edge
  task automatic drive;
    tick();
    req = r;
    r = '0;
  endtask : drive
  task automatic close_out;
    $display("checks %0d, n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic t_reset;
    chk(32'(inst_valid), 32'h0000_0000);
    chk(32'(ctrl_we), 32'h0000_0000);
    chk(32'(mem_req[0].valid), 32'h0000_0000);
    chk(rsp[0].first_source_operand, 32'h0000_0000);
  endtask : t_reset
  // All eight units write and read back in parallel
  task automatic t_parallel;
    for (int k = 0; k < 8; k++)
    begin
      r[k].wr_en = 1'b1;
      r[k].wr_addr = 4'(k % 4 + 4);
      r[k].wr_data = val(k);
      r[k].rd1_addr = 4'(k % 4 + 4);
    end
    drive();
    for (int k = 0; k < 8; k++)
    begin
      r[k].rd1_addr = 4'(k % 4 + 4);
      r[k].rd2_addr = 4'(k % 4 + 4);
    end
    drive();
    for (int k = 0; k < 8; k++)
      chk(rsp[k].first_source_operand, 32'h0000_0000);
    drive();
    for (int k = 0; k < 8; k++)
    begin
      chk(rsp[k].first_source_operand, val(k));
      chk(rsp[k].second_source_operand, val(k));
    end
    chk(32'(rsp[5].first_source_operand.upper_half), 32'h0000_0606);
    chk(32'(rsp[5].first_source_operand.lower_half), 32'h0000_0606);
  endtask : t_parallel
  task automatic t_long;
    r[1].long_wr_en = 1'b1;
    r[1].wr_addr = 4'h3;
    r[1].wr_data = 32'hDEAD_BEEF;
    r[1].wr_hi = 8'h5A;
    r[2].long_wr_en = 1'b1;
    r[2].wr_addr = 4'hA;
    r[2].wr_data = 32'hFFFF_FFFF;
    r[2].wr_hi = 8'hFF;
    r[0].long_wr_en = 1'b1;
    r[0].wr_addr = 4'hC;
    r[0].wr_data = 32'h1234_5678;
    r[0].wr_hi = 8'hC3;
    drive();
    r[0].rd1_addr = 4'h3;
    r[0].rd2_addr = 4'h2;
    r[1].rd1_addr = 4'hA;
    r[1].rd2_addr = 4'hB;
    r[3].rd1_addr = 4'hC;
    r[3].rd2_addr = 4'hD;
    drive();
    drive();
    chk(rsp[0].first_source_operand, 32'h0000_005A);
    chk(rsp[0].second_source_operand, 32'hDEAD_BEEF);
    chk(rsp[1].first_source_operand, 32'h0000_0000);
    chk(rsp[1].second_source_operand, 32'h0000_0000);
    chk(rsp[3].first_source_operand, 32'h1234_5678);
    chk(rsp[3].second_source_operand, 32'h0000_00C3);
    r[0].wr_en = 1'b1;
    r[0].wr_addr = 4'h3;
    r[0].wr_data = 32'hFFFF_FF77;
    drive();
    r[0].long_rd = 1'b1;
    r[0].rd2_addr = 4'h3;
    r[2].long_rd = 1'b1;
    r[2].rd2_addr = 4'h3;
    drive();
    drive();
    chk(rsp[0].second_source_operand, 32'hDEAD_BEEF);
    chk(32'(rsp[0].second_source_hi), 32'h0000_0077);
    chk(32'(rsp[2].second_source_hi), 32'h0000_0000);
  endtask : t_long
  task automatic t_cross;
    r[0].cross2 = 1'b1;
    r[0].rd2_addr = 4'h4;
    r[4].cross1 = 1'b1;
    r[4].rd1_addr = 4'h5;
    drive();
    r[0].cross2 = 1'b1;
    r[0].rd2_addr = 4'h4;
    r[1].cross2 = 1'b1;
    r[1].rd2_addr = 4'h4;
    r[5].cross2 = 1'b1;
    r[5].rd2_addr = 4'h7;
    r[6].cross2 = 1'b1;
    r[6].rd2_addr = 4'h7;
    drive();
    chk(rsp[0].second_source_operand, val(4));
    chk(rsp[4].first_source_operand, val(1));
    chk(32'(cross_conflict), 32'h0000_0000);
    drive();
    chk(rsp[0].second_source_operand, val(4));
    chk(rsp[1].second_source_operand, val(0));
    chk(rsp[5].second_source_operand, val(3));
    chk(rsp[6].second_source_operand, val(7));
    chk(32'(cross_conflict), 32'h0000_0003);
  endtask : t_cross
  task automatic t_cond;
    cond_addr = {4'h0, 4'h3};
    tick();
    chk(32'(cond_true), 32'h0000_0001);
    cond_addr = {4'h5, 4'hA};
    tick();
    chk(32'(cond_true), 32'h0000_0002);
  endtask : t_cond
  task automatic t_mem;
    r[3].mem_en = 1'b1;
    r[3].mem_store = 1'b1;
    r[3].rd1_addr = 4'h5;
    r[3].long_off = 1'b1;
    r[3].offset = 15'h0104;
    r[3].rd2_addr = 4'h6;
    r[7].mem_en = 1'b1;
    r[7].rd1_addr = 4'h4;
    r[7].long_off = 1'b1;
    r[7].offset = 15'h0100;
    drive();
    r[7].mem_en = 1'b1;
    r[7].rd1_addr = 4'h4;
    r[7].mem_sub = 1'b1;
    r[7].offset = 15'h0004;
    drive();
    chk(32'(mem_req[0].store), 32'h0000_0001);
    chk(mem_req[0].addr, 32'h0202_0206);
    chk(mem_req[1].addr, 32'h0505_0605);
    chk(mem_req[0].wdata, val(2));
    chk(32'(mem_req[1].valid), 32'h0000_0001);
    circ_mask[0] = 32'h0000_000F;
    r[3].mem_en = 1'b1;
    r[3].mem_circ = 1'b1;
    r[3].rd1_addr = 4'h5;
    r[3].offset = 15'h000F;
    drive();
    chk(mem_req[1].addr, 32'h0505_0501);
    chk(32'(mem_req[0].valid), 32'h0000_0000);
    drive();
    chk(mem_req[0].addr, 32'h0202_0201);
  endtask : t_mem
  task automatic t_ctrl;
    r[5].ctrl_wr = 1'b1;
    r[5].rd2_addr = 4'h7;
    drive();
    r[1].ctrl_wr = 1'b1;
    r[1].rd2_addr = 4'h7;
    drive();
    chk(32'(ctrl_we), 32'h0000_0001);
    chk(ctrl_wdata, val(7));
    r[5].ctrl_rd = 1'b1;
    r[5].wr_addr = 4'h9;
    r[1].ctrl_rd = 1'b1;
    r[1].wr_addr = 4'h9;
    drive();
    chk(32'(ctrl_we), 32'h0000_0000);
    r[4].rd1_addr = 4'h9;
    r[0].rd1_addr = 4'h9;
    drive();
    drive();
    chk(rsp[4].first_source_operand, val(7));
    chk(rsp[0].first_source_operand, 32'h0000_0000);
  endtask : t_ctrl
  task automatic t_fetch;
    logic [255:0] p;
    for (int i = 0; i < 8; i++)
      p[32*i +: 32] = 32'(32'h1111_1111 * (i + 1));
    fetch_packet = p;
    fetch_valid = 1'b1;
    tick();
    chk(32'(inst_valid), 32'h0000_0001);
    for (int i = 0; i < 8; i++)
      chk(inst[i], p[32*i +: 32]);
    fetch_valid = 1'b0;
    fetch_packet = ~p;
    tick();
    chk(32'(inst_valid), 32'h0000_0000);
    chk(inst[7], 32'h8888_8888);
  endtask : t_fetch
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_parallel();
    t_long();
    t_cross();
    t_cond();
    t_mem();
    t_ctrl();
    t_fetch();
    close_out();
  end
  initial
  begin
    #(40 * 2000);
    n_fail++;
    close_out();
  end
endmodule : dual_register_file_datapath_test
`default_nettype wire
